// ### rtl/emb_pkg.sv
// Operation
// - length field sets size in 64KB steps
// - ready enable bit lets ready end cycles
// - sync select picks raw or synchronised ready
// - enable bit gates bank chip select
// - cycle-length field inserts 0 to 7 waits
// - chip select lasts cycle length plus two
// - bank 0 config resets to 0x7f3d
// - bank 1 config at 0x04 resets 0x0001
// - start address is base field times 2KB
// - bank 0 config is 16-bit read/write
// - ready checked after waits, low adds wait
// - chip select 0 wins on overlap
package emb_pkg;

  localparam int REG_AW = 5;
  localparam int ADDR_W = 23;

  localparam logic [REG_AW-1:0] OFS_BANK0_CONFIG   = 5'h00;
  localparam logic [REG_AW-1:0] OFS_BANK1_CONFIG   = 5'h04;
  localparam logic [REG_AW-1:0] OFS_RSVD_A         = 5'h08;
  localparam logic [REG_AW-1:0] OFS_RSVD_B         = 5'h0c;
  localparam logic [REG_AW-1:0] OFS_BANK1_START    = 5'h10;

  localparam logic [15:0] RST_BANK0_CONFIG = 16'h7f3d;
  localparam logic [15:0] RST_BANK1_CONFIG = 16'h0001;
  localparam logic [15:0] RST_RSVD         = 16'h0001;
  localparam logic [15:0] RST_BANK1_START  = 16'h0000;

  // config field positions
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 8;
  localparam int RDY_EN_BIT = 7;
  localparam int SYNC_BIT = 6;
  localparam int BANK_EN_BIT = 5;
  localparam int CLEN_HI = 4;
  localparam int CLEN_LO = 2;
  localparam int BASE_HI = 11;
  localparam int BASE_LO = 0;
  localparam int BASE_SHIFT = 11;
  localparam int SIZE_SHIFT = 16;

  // extra cycles beyond the wait states: the chip select spans waits plus two
  localparam logic [3:0] CS_EXTRA = 4'h2;

  typedef struct packed {
    logic [6:0] sizeCode;
    logic       readyEn;
    logic       syncSel;
    logic       bankEn;
    logic [2:0] waitStates;
  } emb_bank_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_READY = 2'b10,
    ST_DONE  = 2'b11
  } emb_state_e;

endpackage

// ### rtl/emb_ready_sync.sv
`timescale 1ns/100ps
module emb_ready_sync
  import emb_pkg::*;
#(
  parameter int STAGES = 2
)
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic readyRaw,
  output logic      readySync
);

  logic [STAGES-1:0] chain_ff;

  // plain shift chain; only the last stage is observed
  always_ff @(posedge core_clk)
  begin
    if (rst)
      chain_ff <= '0;
    else
      chain_ff <= {chain_ff[STAGES-2:0], readyRaw};
  end

  assign readySync = chain_ff[STAGES-1];

endmodule

// ### rtl/emb_bank_decode.sv
`timescale 1ns/100ps
module emb_bank_decode
  import emb_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire emb_bank_cfg_s     cfg0,
  input  wire emb_bank_cfg_s     cfg1,
  input  wire logic [11:0]       base1,
  output logic                   hit0,
  output logic                   hit1
);

  logic [ADDR_W:0] start1;
  logic [ADDR_W:0] size1;
  logic [ADDR_W:0] size0;
  logic [ADDR_W:0] a;
  logic            in1;

  always_comb
  begin
    a      = {1'b0, addr};
    start1 = {1'b0, base1, {BASE_SHIFT{1'b0}}};
    size0  = ({17'h00000, cfg0.sizeCode} + 24'h000001) << SIZE_SHIFT;
    size1  = ({17'h00000, cfg1.sizeCode} + 24'h000001) << SIZE_SHIFT;
    in1    = (a >= start1) && (a < (start1 + size1));
    hit0   = cfg0.bankEn && (a < size0);
    hit1   = cfg1.bankEn && in1 && !hit0;
  end

endmodule

// ### rtl/ext_mem_bank_config.sv
`timescale 1ns/100ps
module emb_ext_mem_bank_config
  import emb_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  // register port
  input  wire logic              regSel,
  input  wire logic              regWrite,
  input  wire logic [REG_AW-1:0] regAddr,
  input  wire logic [15:0]       regWdata,
  output logic [15:0]            regRdata,
  // access request from the system side
  input  wire logic              accReq,
  input  wire logic [ADDR_W-1:0] accAddr,
  output logic                   accBusy,
  output logic                   accDone,
  // external memory port
  input  wire logic              extReady,
  output logic                   chipSelectZeroN,
  output logic                   chipSelectOneN
);

  // ****************************************
  // local sizes
  // ****************************************
  // two flops cost two waits but keep a metastable ready out of the state decision
  localparam int         SYNC_STAGES = 2;
  localparam int         NUM_BANKS   = 2;
  localparam logic [3:0] CNT_FIRST   = 4'h1;

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] bank0Config_ff;
  logic [15:0] bank1Config_ff;
  logic [15:0] rsvdA_ff;
  logic [15:0] rsvdB_ff;
  logic [15:0] bank1Start_ff;
  logic        wr;
  logic        wrBank0Cfg;
  logic        wrBank1Cfg;
  logic        wrRsvdA;
  logic        wrRsvdB;
  logic        wrBank1Start;

  assign wr           = regSel && regWrite;
  assign wrBank0Cfg   = wr && (regAddr == OFS_BANK0_CONFIG);
  assign wrBank1Cfg   = wr && (regAddr == OFS_BANK1_CONFIG);
  assign wrRsvdA      = wr && (regAddr == OFS_RSVD_A);
  assign wrRsvdB      = wr && (regAddr == OFS_RSVD_B);
  assign wrBank1Start = wr && (regAddr == OFS_BANK1_START);

  // all 16 bits are stored as written; keeping reserved bits right is up to software
  always_ff @(posedge core_clk)
  begin
    if (rst)
      bank0Config_ff <= RST_BANK0_CONFIG;
    else if (wrBank0Cfg)
      bank0Config_ff <= regWdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      bank1Config_ff <= RST_BANK1_CONFIG;
    else if (wrBank1Cfg)
      bank1Config_ff <= regWdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rsvdA_ff <= RST_RSVD;
    else if (wrRsvdA)
      rsvdA_ff <= regWdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rsvdB_ff <= RST_RSVD;
    else if (wrRsvdB)
      rsvdB_ff <= regWdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      bank1Start_ff <= RST_BANK1_START;
    else if (wrBank1Start)
      bank1Start_ff <= regWdata;
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge core_clk)
  begin
    if (rst)
      regRdata <= 16'h0000;
    else if (regSel && !regWrite)
    begin
      case (regAddr)
        OFS_BANK0_CONFIG: regRdata <= bank0Config_ff;
        OFS_BANK1_CONFIG: regRdata <= bank1Config_ff;
        OFS_RSVD_A:       regRdata <= rsvdA_ff;
        OFS_RSVD_B:       regRdata <= rsvdB_ff;
        OFS_BANK1_START:  regRdata <= bank1Start_ff;
        default:          regRdata <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // field extraction
  // ****************************************
  emb_bank_cfg_s cfg0;
  emb_bank_cfg_s cfg1;
  emb_bank_cfg_s cfgSel;
  logic [15:0]   bankWord [NUM_BANKS];
  emb_bank_cfg_s bankCfg  [NUM_BANKS];

  assign bankWord[0] = bank0Config_ff;
  assign bankWord[1] = bank1Config_ff;

  // both banks share one field layout
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_field
    assign bankCfg[b] = '{sizeCode:   bankWord[b][LEN_HI:LEN_LO],
                          readyEn:    bankWord[b][RDY_EN_BIT],
                          syncSel:    bankWord[b][SYNC_BIT],
                          bankEn:     bankWord[b][BANK_EN_BIT],
                          waitStates: bankWord[b][CLEN_HI:CLEN_LO]};
  end

  assign cfg0 = bankCfg[0];
  assign cfg1 = bankCfg[1];

  // ****************************************
  // decode and ready paths
  // ****************************************
  logic hit0;
  logic hit1;
  logic readySync;

  // bank 0 is fixed at address zero; only bank 1 has a movable start
  emb_bank_decode u_decode
  (
    .addr  (accAddr),
    .cfg0  (cfg0),
    .cfg1  (cfg1),
    .base1 (bank1Start_ff[BASE_HI:BASE_LO]),
    .hit0  (hit0),
    .hit1  (hit1)
  );

  // the chain always runs so it is already settled when a bank selects it
  emb_ready_sync #(.STAGES(SYNC_STAGES)) u_sync
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .readyRaw  (extReady),
    .readySync (readySync)
  );

  // ****************************************
  // access sequencer
  // ****************************************
  emb_state_e state_ff;
  emb_state_e nxt_state;
  logic       bankSel_ff;   // 0 = bank 0, 1 = bank 1
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic       readyNow;
  logic       nxt_cs0;
  logic       nxt_cs1;

  assign cfgSel = bankSel_ff ? cfg1 : cfg0;
  // raw path relies on software keeping waits above four for setup margin
  assign readyNow = cfgSel.syncSel ? readySync : extReady;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_cs0   = 1'b0;
    nxt_cs1   = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (accReq && (hit0 || hit1))
        begin
          nxt_state = ST_WAIT;
          nxt_cnt   = CNT_FIRST;
          nxt_cs0   = hit0;
          nxt_cs1   = hit1;
        end
        else if (accReq)
          nxt_state = ST_DONE;        // no bank claims it: finish with no select
      end
      ST_WAIT:
      begin
        nxt_cs0 = !bankSel_ff;
        nxt_cs1 = bankSel_ff;
        nxt_cnt = cnt_ff + 4'h1;
        // chip select spans waitStates + 2 cycles unless ready stretches it;
        // cnt_ff already includes the cycle in which the select fell
        if (cnt_ff >= ({1'b0, cfgSel.waitStates} + CS_EXTRA))
        begin
          if (cfgSel.readyEn && !readyNow)
            nxt_state = ST_READY;
          else
          begin
            nxt_state = ST_DONE;
            nxt_cs0   = 1'b0;
            nxt_cs1   = 1'b0;
          end
        end
      end
      ST_READY:
      begin
        // one extra wait per low sample
        if (readyNow)
          nxt_state = ST_DONE;
        else
        begin
          nxt_cs0 = !bankSel_ff;
          nxt_cs1 = bankSel_ff;
        end
      end
      // the done cycle gives the requester one edge to drop accReq
      ST_DONE:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // cycles of select low in ST_WAIT; restarts at CNT_FIRST for every accepted request
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= nxt_cnt;
  end

  // bank is latched when the request is taken, so the select cannot move mid-access
  always_ff @(posedge core_clk)
  begin
    if (rst)
      bankSel_ff <= 1'b0;
    else if (state_ff == ST_IDLE)
      bankSel_ff <= hit1;
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
      chipSelectZeroN <= 1'b1;
    else
      chipSelectZeroN <= !nxt_cs0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      chipSelectOneN <= 1'b1;
    else
      chipSelectOneN <= !nxt_cs1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      accBusy <= 1'b0;
    else
      accBusy <= (nxt_state != ST_IDLE);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      accDone <= 1'b0;
    else
      accDone <= (nxt_state == ST_DONE);
  end

endmodule

// ### bench/emb_assertions.sv
`timescale 1ns/100ps
module emb_assertions
  import emb_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              regSel,
  input wire logic              regWrite,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [15:0]       regWdata,
  input wire logic [15:0]       regRdata,
  input wire logic              accReq,
  input wire logic [ADDR_W-1:0] accAddr,
  input wire logic              accBusy,
  input wire logic              accDone,
  input wire logic              extReady,
  input wire logic              chipSelectZeroN,
  input wire logic              chipSelectOneN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // port checks
  // ****************************************
  AST_ONE_SELECT: assert property (chipSelectZeroN || chipSelectOneN)
    else $error("both chip selects low");
  AST_DONE_PULSE: assert property (accDone |=> !accDone)
    else $error("done longer than one cycle");
  AST_DONE_RELEASED: assert property (accDone |-> chipSelectZeroN && chipSelectOneN && accBusy)
    else $error("select still low at done");
  AST_SEL_BUSY: assert property (!(chipSelectZeroN && chipSelectOneN) |-> accBusy)
    else $error("select low outside an access");
  AST_CS0_END: assert property ($rose(chipSelectZeroN) |-> accDone)
    else $error("select 0 released without done");
  AST_CS1_END: assert property ($rose(chipSelectOneN) |-> accDone)
    else $error("select 1 released without done");
  AST_CS0_MIN: assert property ($fell(chipSelectZeroN) |=> !chipSelectZeroN)
    else $error("select 0 shorter than two cycles");
  AST_CS1_MIN: assert property ($fell(chipSelectOneN) |=> !chipSelectOneN)
    else $error("select 1 shorter than two cycles");
  cover property ($fell(chipSelectZeroN));
  cover property ($fell(chipSelectOneN));
  cover property (regSel && regWrite);
endmodule

bind emb_ext_mem_bank_config emb_assertions u_ast (.*);

// ### bench/emb_mem_model.sv
`timescale 1ns/100ps
module emb_mem_model
(
  input wire logic       core_clk,
  input wire logic       chipSelectZeroN,
  input wire logic       chipSelectOneN,
  input wire logic [3:0] readyDelay,
  output logic           extReady
);
  logic [3:0] waitCnt;
  logic       toggle = 1'b0;
  // unselected memory does not drive a steady ready, so show a moving pattern
  always_ff @(posedge core_clk)
  begin
    toggle <= !toggle;
    waitCnt <= (chipSelectZeroN && chipSelectOneN) ? 4'h0 : waitCnt + 4'h1;
  end
  assign extReady = (chipSelectZeroN && chipSelectOneN) ? toggle : (waitCnt >= readyDelay);
endmodule

// ### bench/emb_ext_mem_bank_config_test.sv
`timescale 1ns/100ps
module emb_ext_mem_bank_config_test
  import emb_pkg::*;
;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic              regSel = 1'b0;
  logic              regWrite = 1'b0;
  logic [REG_AW-1:0] regAddr = 5'h00;
  logic [15:0]       regWdata = 16'h0000;
  logic [15:0]       regRdata;
  logic              accReq = 1'b0;
  logic [ADDR_W-1:0] accAddr = 23'h000000;
  logic              accBusy, accDone, extReady, chipSelectZeroN, chipSelectOneN;
  logic [3:0]        readyDelay = 4'h0;
  int                nMismatch = 0;
  int                checkCount = 0;
  int                cycles = 0;
  emb_ext_mem_bank_config dut (.*);
  emb_mem_model u_mem (.*);
  initial forever #20 core_clk = ~core_clk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    if (nMismatch == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checkCount++;
    if (g !== e)
    begin
      $display("FAIL %s exp %h got %h", nm, e, g);
      nMismatch++;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    {regSel, regWrite, regAddr, regWdata} <= {2'b11, a, d};
    @(posedge core_clk);
    regSel <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    {regSel, regWrite, regAddr} <= {2'b10, a};
    @(posedge core_clk);
    regSel <= 1'b0;
    @(negedge core_clk);
    chk("regRdata", e, regRdata);
  endtask
  // counts select-low cycles until done; bounded against a hang
  task automatic acc(input logic [22:0] a, input logic [15:0] e0, input logic [15:0] e1);
    logic [15:0] c0, c1, cb;
    int n;
    c0 = 16'h0000;
    c1 = 16'h0000;
    cb = 16'h0000;
    n = 0;
    @(posedge core_clk);
    {accReq, accAddr} <= {1'b1, a};
    do
    begin
      @(negedge core_clk);
      c0 += 16'(!chipSelectZeroN);
      c1 += 16'(!chipSelectOneN);
      cb += 16'(accBusy);
      n++;
    end while (accDone !== 1'b1 && n < 40);
    chk("accDone", 16'h0001, 16'(accDone));
    @(posedge core_clk);
    accReq <= 1'b0;
    chk("cs0 cycles", e0, c0);
    chk("cs1 cycles", e1, c1);
    chk("busy cycles", e0 + e1 + 16'h0001, cb);
    @(posedge core_clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(5'h00, 16'h7f3d);
    rd(5'h04, 16'h0001);
    rd(5'h08, 16'h0001);
    rd(5'h0c, 16'h0001);
    rd(5'h10, 16'h0000);
    rd(5'h14, 16'h0000);
    wr(5'h08, 16'h0001);
    wr(5'h0c, 16'h0001);
    wr(5'h00, 16'h2a55);
    rd(5'h00, 16'h2a55);
  endtask
  task automatic t_waits();
    for (int i = 0; i < 8; i++)
    begin
      wr(5'h00, 16'h7f21 | 16'(i << 2));
      acc(23'h000000, 16'(i + 2), 16'h0000);
    end
  endtask
  task automatic t_enable_size();
    wr(5'h00, 16'h7f01);
    acc(23'h000000, 16'h0000, 16'h0000);
    wr(5'h00, 16'h0121);
    acc(23'h01ffff, 16'h0002, 16'h0000);
    acc(23'h020000, 16'h0000, 16'h0000);
  endtask
  task automatic t_bank1();
    wr(5'h00, 16'h0021);
    wr(5'h04, 16'h0025);
    wr(5'h10, 16'h0021);
    acc(23'h0107ff, 16'h0000, 16'h0000);
    acc(23'h010800, 16'h0000, 16'h0003);
    acc(23'h0207ff, 16'h0000, 16'h0003);
    acc(23'h020800, 16'h0000, 16'h0000);
    wr(5'h00, 16'h7f21);
    acc(23'h010800, 16'h0002, 16'h0000);
    wr(5'h04, 16'h0001);
    wr(5'h10, 16'h0000);
    wr(5'h00, 16'h0021);
    acc(23'h010800, 16'h0000, 16'h0000);
  endtask
  task automatic t_ready();
    wr(5'h00, 16'h7fb5);
    readyDelay <= 4'h8;
    acc(23'h000000, 16'h0009, 16'h0000);
    readyDelay <= 4'h0;
    acc(23'h000000, 16'h0007, 16'h0000);
    wr(5'h00, 16'h7ff5);
    readyDelay <= 4'h8;
    acc(23'h000000, 16'h000b, 16'h0000);
    wr(5'h00, 16'h7f35);
    acc(23'h000000, 16'h0007, 16'h0000);
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      nMismatch++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_waits();
    t_enable_size();
    t_bank1();
    t_ready();
    print_verdict();
  end
endmodule
